/* File: inc/psp_pkg.sv */
// shared constants, register map and state types for the parallel slave port pair
package psp_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned STROBE_NS = 80;
  localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RECOVER_NS = 60;
  localparam int unsigned RECOVER_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // device register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_DATA_LATCH = 8'h08;
  localparam logic [7:0] IDX_CTL_DATA = 8'h09;
  localparam logic [7:0] IDX_DATA_DIR = 8'h88;
  localparam logic [7:0] IDX_STATUS_DIR = 8'h89;
  localparam logic [7:0] IDX_PIN_CFG = 8'h9F;
  localparam logic [7:0] IDX_IRQ_FLAG = 8'h0C;
  localparam logic [11:0] ADDR_DATA_LATCH = {2'h0, IDX_DATA_LATCH, 2'h0};
  localparam logic [11:0] ADDR_CTL_DATA = {2'h0, IDX_CTL_DATA, 2'h0};
  localparam logic [11:0] ADDR_DATA_DIR = {2'h0, IDX_DATA_DIR, 2'h0};
  localparam logic [11:0] ADDR_STATUS_DIR = {2'h0, IDX_STATUS_DIR, 2'h0};
  localparam logic [11:0] ADDR_PIN_CFG = {2'h0, IDX_PIN_CFG, 2'h0};
  localparam logic [11:0] ADDR_IRQ_FLAG = {2'h0, IDX_IRQ_FLAG, 2'h0};

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned BIT_INPUT_FULL = 7;
  localparam int unsigned BIT_OUTPUT_FULL = 6;
  localparam int unsigned BIT_OVERRUN = 5;
  localparam int unsigned BIT_PORT_SELECT = 4;
  localparam int unsigned BIT_IRQ_FLAG = 7;
  localparam int unsigned PIN_RD = 0;
  localparam int unsigned PIN_WR = 1;
  localparam int unsigned PIN_CS = 2;
  localparam logic [2:0] CTL_DIR_RESET = 3'h7;
  localparam logic [7:0] DATA_DIR_RESET = 8'hFF;
  localparam logic [7:0] PIN_CFG_RESET = 8'h00;
  localparam logic [7:0] PIN_CFG_WMASK = 8'hCF;
  localparam logic [3:0] CFG_DIGITAL_A = 4'h6;
  localparam logic [3:0] CFG_DIGITAL_B = 4'h7;

  // ----------------------------------------------------------------
  // host controller registers
  // ----------------------------------------------------------------
  localparam logic [11:0] HADDR_CMD = 12'h000;
  localparam logic [11:0] HADDR_TX = 12'h004;
  localparam logic [11:0] HADDR_STATUS = 12'h008;
  localparam logic [11:0] HADDR_RX = 12'h00C;
  localparam int unsigned CMD_WRITE = 0;
  localparam int unsigned CMD_READ = 1;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_STROBE = 2'b01,
    H_RECOVER = 2'b10
  } host_state_t;

endpackage : psp_pkg

/* File: inc/psp_link_if.sv */
// pin-level link between the slave port device and the external processor
`timescale 1ns/1ps
`default_nettype none
interface psp_link_if;
  logic [7:0] dev_data_o;
  logic [7:0] dev_data_oe;
  logic [7:0] host_data_o;
  logic [7:0] host_data_oe;
  logic [2:0] dev_ctl_o;
  logic [2:0] dev_ctl_oe;
  logic [2:0] host_ctl_o;
  logic [2:0] host_ctl_oe;
  logic [7:0] data_lvl;
  logic [2:0] ctl_lvl;

  // undriven wires float high through pull-ups
  assign data_lvl = (dev_data_o & dev_data_oe) | (host_data_o & host_data_oe)
                  | ~(dev_data_oe | host_data_oe);
  assign ctl_lvl = (dev_ctl_o & dev_ctl_oe) | (host_ctl_o & host_ctl_oe)
                 | ~(dev_ctl_oe | host_ctl_oe);

  modport device (
    output dev_data_o, dev_data_oe, dev_ctl_o, dev_ctl_oe,
    input data_lvl, ctl_lvl
  );
  modport host (
    output host_data_o, host_data_oe, host_ctl_o, host_ctl_oe,
    input data_lvl, ctl_lvl
  );
endinterface : psp_link_if
`default_nettype wire

/* File: verilog/psp_sync.sv */
// two-flop synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none
module psp_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  // the first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : psp_sync
`default_nettype wire

/* File: verilog/psp_device.sv */
// parallel slave port device end: pin control, flags and apb register file
// Summary of operation
// - select bit turns control pins into strobes
// - firmware sets pins input and digital first
// - per-pin direction bit, one means input
// - read strobe with select drives output latch
// - write strobe with select captures data pins
// - select active low; deselected strobes ignored
// - analog-configured control pins read as zero
// - direction bits drive pins even when analog
// - reset leaves control pins analog, reading zero
// - input-full flag bit 7, read-only
// - output-full flag bit 6, read-only
// - overrun flag bit 5, firmware clears it
// - flag, select and direction reset values
// - write end sets input-full and irq later
// - a data latch read or leaving port mode clears input-full
// - read start clears output-full; end sets irq
// - outside port mode full flags held clear
`timescale 1ns/1ps
`default_nettype none
module psp_device (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  psp_link_if.device link
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] ctl_s;
  logic [7:0] data_s;

  psp_sync #(.WIDTH(3), .RST_VAL(3'h7)) u_ctl_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(link.ctl_lvl),
    .q(ctl_s)
  );
  psp_sync #(.WIDTH(8), .RST_VAL(8'hFF)) u_data_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(link.data_lvl),
    .q(data_s)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] out_latch_reg;
  logic [7:0] in_latch_reg;
  logic [7:0] data_dir_reg;
  logic [2:0] ctl_out_reg;
  logic [2:0] ctl_dir_reg;
  logic [7:0] pin_cfg_reg;
  logic port_select_reg;
  logic input_full_reg;
  logic output_full_reg;
  logic overrun_reg;
  logic irq_flag_reg;
  logic rd_act_reg;
  logic wr_act_reg;
  logic rd_end_reg;
  logic wr_end_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;

  // ----------------------------------------------------------------
  // access detection
  // ----------------------------------------------------------------
  logic pins_digital;
  logic rd_act;
  logic wr_act;
  logic rd_start;
  logic rd_end;
  logic wr_start;
  logic wr_end;

  assign pins_digital = (pin_cfg_reg[3:0] == psp_pkg::CFG_DIGITAL_A)
                     || (pin_cfg_reg[3:0] == psp_pkg::CFG_DIGITAL_B);
  // strobes only count while selected and in port mode
  assign rd_act = port_select_reg & ~ctl_s[psp_pkg::PIN_CS] & ~ctl_s[psp_pkg::PIN_RD];
  assign wr_act = port_select_reg & ~ctl_s[psp_pkg::PIN_CS] & ~ctl_s[psp_pkg::PIN_WR];
  assign rd_start = rd_act & ~rd_act_reg;
  assign rd_end = ~rd_act & rd_act_reg;
  assign wr_start = wr_act & ~wr_act_reg;
  assign wr_end = ~wr_act & wr_act_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_act_reg <= 1'b0;
      wr_act_reg <= 1'b0;
      rd_end_reg <= 1'b0;
      wr_end_reg <= 1'b0;
    end else begin
      rd_act_reg <= rd_act;
      wr_act_reg <= wr_act;
      rd_end_reg <= rd_end;
      wr_end_reg <= wr_end;
    end
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic setup;
  logic access;
  logic mapped;
  logic reg_wr;
  logic data_rd;
  logic [31:0] rd_mux;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign mapped = (paddr == psp_pkg::ADDR_DATA_LATCH) || (paddr == psp_pkg::ADDR_CTL_DATA)
               || (paddr == psp_pkg::ADDR_DATA_DIR) || (paddr == psp_pkg::ADDR_STATUS_DIR)
               || (paddr == psp_pkg::ADDR_PIN_CFG) || (paddr == psp_pkg::ADDR_IRQ_FLAG);
  assign reg_wr = access & pwrite & mapped;
  assign data_rd = access & ~pwrite & (paddr == psp_pkg::ADDR_DATA_LATCH);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      psp_pkg::ADDR_DATA_LATCH: rd_mux[7:0] = port_select_reg ? in_latch_reg : data_s;
      psp_pkg::ADDR_CTL_DATA: rd_mux[2:0] = pins_digital ? ctl_s : 3'h0;
      psp_pkg::ADDR_DATA_DIR: rd_mux[7:0] = data_dir_reg;
      psp_pkg::ADDR_STATUS_DIR: rd_mux[7:0] = {input_full_reg, output_full_reg, overrun_reg,
                                               port_select_reg, 1'b0, ctl_dir_reg};
      psp_pkg::ADDR_PIN_CFG: rd_mux[7:0] = pin_cfg_reg;
      psp_pkg::ADDR_IRQ_FLAG: rd_mux[psp_pkg::BIT_IRQ_FLAG] = irq_flag_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data is caught in the setup cycle so the access phase is always one cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (setup) begin
      prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_reg <= ~mapped;
    end
  end

  assign prdata = prdata_reg;
  assign pready = access;
  assign pslverr = access & pslverr_reg;

  // ----------------------------------------------------------------
  // firmware-written configuration
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_latch_reg <= 8'h00;
      data_dir_reg <= psp_pkg::DATA_DIR_RESET;
      ctl_out_reg <= 3'h0;
      ctl_dir_reg <= psp_pkg::CTL_DIR_RESET;
      port_select_reg <= 1'b0;
      pin_cfg_reg <= psp_pkg::PIN_CFG_RESET;
    end else if (reg_wr) begin
      case (paddr)
        psp_pkg::ADDR_DATA_LATCH: out_latch_reg <= pwdata[7:0];
        psp_pkg::ADDR_CTL_DATA: ctl_out_reg <= pwdata[2:0];
        psp_pkg::ADDR_DATA_DIR: data_dir_reg <= pwdata[7:0];
        psp_pkg::ADDR_STATUS_DIR: begin
          port_select_reg <= pwdata[psp_pkg::BIT_PORT_SELECT];
          ctl_dir_reg <= pwdata[2:0];
        end
        psp_pkg::ADDR_PIN_CFG: pin_cfg_reg <= pwdata[7:0] & psp_pkg::PIN_CFG_WMASK;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // input latch and flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_latch_reg <= 8'h00;
    end else if (wr_act) begin
      in_latch_reg <= data_s;
    end
  end

  // the set one cycle after the strobe ends stands in for the later phase of the cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      input_full_reg <= 1'b0;
    end else if (!port_select_reg) begin
      input_full_reg <= 1'b0;
    end else if (wr_end_reg) begin
      input_full_reg <= 1'b1;
    end else if (data_rd) begin
      input_full_reg <= 1'b0;
    end
  end

  // a firmware write in the same cycle as a read start wins: that byte is still unread
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      output_full_reg <= 1'b0;
    end else if (!port_select_reg) begin
      output_full_reg <= 1'b0;
    end else if (reg_wr && paddr == psp_pkg::ADDR_DATA_LATCH) begin
      output_full_reg <= 1'b1;
    end else if (rd_start) begin
      output_full_reg <= 1'b0;
    end
  end

  // overrun survives leaving port mode; hardware set wins over a firmware clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_reg <= 1'b0;
    end else if (wr_start && input_full_reg) begin
      overrun_reg <= 1'b1;
    end else if (reg_wr && paddr == psp_pkg::ADDR_STATUS_DIR) begin
      overrun_reg <= pwdata[psp_pkg::BIT_OVERRUN];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_flag_reg <= 1'b0;
    end else if (wr_end_reg || rd_end_reg) begin
      irq_flag_reg <= 1'b1;
    end else if (reg_wr && paddr == psp_pkg::ADDR_IRQ_FLAG) begin
      irq_flag_reg <= pwdata[psp_pkg::BIT_IRQ_FLAG];
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // in port mode the external read decides the data direction, not the direction register
  assign link.dev_data_o = out_latch_reg;
  assign link.dev_data_oe = port_select_reg ? {8{rd_act}} : ~data_dir_reg;
  // direction bits act even in analog or port mode; firmware keeps them at input
  assign link.dev_ctl_o = ctl_out_reg;
  assign link.dev_ctl_oe = ~ctl_dir_reg;

endmodule : psp_device
`default_nettype wire

/* File: verilog/psp_host.sv */
// external processor end: apb-commanded byte reads and writes over the strobes
`timescale 1ns/1ps
`default_nettype none
module psp_host (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  psp_link_if.host link
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  psp_pkg::host_state_t state_reg;
  logic [7:0] cnt_reg;
  logic is_read_reg;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  logic [7:0] data_s;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic access;
  logic mapped;
  logic cmd_wr;
  logic [31:0] rd_mux;

  psp_sync #(.WIDTH(8), .RST_VAL(8'hFF)) u_data_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(link.data_lvl),
    .q(data_s)
  );

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  assign access = psel & penable;
  assign mapped = (paddr == psp_pkg::HADDR_CMD) || (paddr == psp_pkg::HADDR_TX)
               || (paddr == psp_pkg::HADDR_STATUS) || (paddr == psp_pkg::HADDR_RX);
  assign cmd_wr = access & pwrite & (paddr == psp_pkg::HADDR_CMD) & (state_reg == psp_pkg::H_IDLE);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      psp_pkg::HADDR_TX: rd_mux[7:0] = tx_reg;
      psp_pkg::HADDR_STATUS: rd_mux[0] = (state_reg != psp_pkg::H_IDLE);
      psp_pkg::HADDR_RX: rd_mux[7:0] = rx_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (psel && !penable) begin
      prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_reg <= ~mapped;
    end
  end

  assign prdata = prdata_reg;
  assign pready = access;
  assign pslverr = access & pslverr_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_reg <= 8'h00;
    end else if (access && pwrite && paddr == psp_pkg::HADDR_TX) begin
      tx_reg <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // strobe sequencer
  // ----------------------------------------------------------------
  // commands while busy are dropped; software polls the busy bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= psp_pkg::H_IDLE;
      cnt_reg <= 8'h00;
      is_read_reg <= 1'b0;
    end else begin
      case (state_reg)
        psp_pkg::H_IDLE: begin
          if (cmd_wr && (pwdata[psp_pkg::CMD_WRITE] || pwdata[psp_pkg::CMD_READ])) begin
            state_reg <= psp_pkg::H_STROBE;
            is_read_reg <= pwdata[psp_pkg::CMD_READ];
            cnt_reg <= 8'(psp_pkg::STROBE_CYC - 1);
          end
        end
        psp_pkg::H_STROBE: begin
          if (cnt_reg == 8'h00) begin
            state_reg <= psp_pkg::H_RECOVER;
            cnt_reg <= 8'(psp_pkg::RECOVER_CYC - 1);
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        psp_pkg::H_RECOVER: begin
          if (cnt_reg == 8'h00) begin
            state_reg <= psp_pkg::H_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        default: state_reg <= psp_pkg::H_IDLE;
      endcase
    end
  end

  // sampled at the last strobe cycle, well after the device has turned the bus round
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_reg <= 8'h00;
    end else if (state_reg == psp_pkg::H_STROBE && is_read_reg && cnt_reg == 8'h00) begin
      rx_reg <= data_s;
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  logic strobing;
  assign strobing = (state_reg == psp_pkg::H_STROBE);
  assign link.host_ctl_oe = 3'h7;
  assign link.host_ctl_o = {~strobing, ~(strobing & ~is_read_reg),
                            ~(strobing & is_read_reg)};
  assign link.host_data_o = tx_reg;
  assign link.host_data_oe = {8{strobing & ~is_read_reg}};

endmodule : psp_host
`default_nettype wire

/* File: testbench/psp_link_sva.sv */
// pin-level checker for the link between the slave port device and the host end
`timescale 1ns/1ps
`default_nettype none
module psp_link_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] dev_data_o,
  input wire logic [7:0] dev_data_oe,
  input wire logic [7:0] host_data_oe,
  input wire logic [2:0] host_ctl_oe,
  input wire logic [7:0] data_lvl,
  input wire logic [2:0] ctl_lvl
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_no_contention;
    (dev_data_oe & host_data_oe) == 8'h00;
  endproperty
  a_no_contention: assert property (p_no_contention)
    else $error("device and host drive the data pins together");

  property p_whole_byte;
    dev_data_oe != 8'h00 |-> dev_data_oe == 8'hFF && data_lvl == dev_data_o;
  endproperty
  a_whole_byte: assert property (p_whole_byte)
    else $error("device read drive is not the full output latch");

  // drive may only follow a read seen through the two-flop synchroniser
  property p_drive_cause;
    $rose(dev_data_oe[0]) |-> $past(ctl_lvl[0], 2) == 1'b0 && $past(ctl_lvl[2], 2) == 1'b0;
  endproperty
  a_drive_cause: assert property (p_drive_cause)
    else $error("data drive began without a synchronised selected read");

  property p_deselect_quiet;
    ctl_lvl[2] [*3] |-> dev_data_oe == 8'h00;
  endproperty
  a_deselect_quiet: assert property (p_deselect_quiet)
    else $error("data pins driven while deselected");

  property p_read_release;
    $rose(ctl_lvl[0]) |-> ##2 dev_data_oe == 8'h00;
  endproperty
  a_read_release: assert property (p_read_release)
    else $error("data drive outlasted the read strobe");

  property p_write_data;
    !ctl_lvl[1] && !ctl_lvl[2] |-> host_data_oe == 8'hFF;
  endproperty
  a_write_data: assert property (p_write_data)
    else $error("write strobe low without host data on the pins");

  property p_strobe_len;
    $fell(ctl_lvl[2]) |-> !ctl_lvl[2] [*8];
  endproperty
  a_strobe_len: assert property (p_strobe_len)
    else $error("select held low for fewer than eight cycles");

  property p_recover_len;
    $rose(ctl_lvl[2]) |-> ctl_lvl[2] [*6];
  endproperty
  a_recover_len: assert property (p_recover_len)
    else $error("select idle for fewer than six cycles");

  property p_strobe_select;
    (!ctl_lvl[0] || !ctl_lvl[1]) |-> !ctl_lvl[2] && (ctl_lvl[0] || ctl_lvl[1]);
  endproperty
  a_strobe_select: assert property (p_strobe_select)
    else $error("strobe low without select or both strobes low");

  property p_host_ctl;
    ctl_lvl[1] |-> host_ctl_oe == 3'h7 && host_data_oe == 8'h00;
  endproperty
  a_host_ctl: assert property (p_host_ctl)
    else $error("host drives data pins outside its write strobe");

  // ----------------------------------------------------------------
  // coverage
  // ----------------------------------------------------------------
  c_read_drive: cover property ($rose(dev_data_oe[0]));
  c_write: cover property ($fell(ctl_lvl[1]));
  c_read: cover property ($fell(ctl_lvl[0]));
endmodule : psp_link_sva
`default_nettype wire

/* File: testbench/parallel_slave_port_control_tb.sv */
// self-checking bench: device and host ends joined over the pin link
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module parallel_slave_port_control_tb;
  localparam bit DEV = 1'b1;
  localparam bit HOST = 1'b0;
  logic clk;
  logic rst_n;
  logic [11:0] paddr;
  logic psel_d;
  logic psel_h;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata_d;
  logic [31:0] prdata_h;
  logic pready_d;
  logic pready_h;
  logic pslverr_d;
  logic pslverr_h;
  logic last_err;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;

  psp_link_if link ();
  psp_device i_psp_device (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel_d),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata_d),
    .pready(pready_d), .pslverr(pslverr_d), .link(link));
  psp_host i_psp_host (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel_h),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata_h),
    .pready(pready_h), .pslverr(pslverr_h), .link(link));
  psp_link_sva i_psp_link_sva (.clk(clk), .rst_n(rst_n), .dev_data_o(link.dev_data_o),
    .dev_data_oe(link.dev_data_oe), .host_data_oe(link.host_data_oe),
    .host_ctl_oe(link.host_ctl_oe), .data_lvl(link.data_lvl), .ctl_lvl(link.ctl_lvl));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  // both slaves share address, data and penable; psel picks the end
  task automatic apb(input bit dev, input logic [11:0] a, input bit w,
                     input logic [31:0] wd, output logic [31:0] rd_data);
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    psel_d <= dev;
    psel_h <= !dev;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while ((dev ? pready_d : pready_h) !== 1'b1);
    rd_data = dev ? prdata_d : prdata_h;
    last_err = dev ? pslverr_d : pslverr_h;
    psel_d <= 1'b0;
    psel_h <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input bit dev, input logic [11:0] a, input logic [31:0] d);
    logic [31:0] unused;
    apb(dev, a, 1'b1, d, unused);
  endtask : wr

  task automatic chk(input bit dev, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] got;
    apb(dev, a, 1'b0, 32'h0, got);
    `CHK(got, exp)
  endtask : chk

  task automatic host_wait();
    logic [31:0] s;
    s = 32'h1;
    for (int i = 0; i < 40 && s[0] !== 1'b0; i++) begin
      apb(HOST, psp_pkg::HADDR_STATUS, 1'b0, 32'h0, s);
    end
    `CHK(s[0], 1'b0)
  endtask : host_wait

  task automatic host_send(input logic [7:0] b);
    wr(HOST, psp_pkg::HADDR_TX, {24'h0, b});
    wr(HOST, psp_pkg::HADDR_CMD, 32'h1);
    host_wait();
  endtask : host_send

  task automatic host_fetch(input logic [7:0] exp);
    wr(HOST, psp_pkg::HADDR_CMD, 32'h2);
    host_wait();
    chk(HOST, psp_pkg::HADDR_RX, {24'h0, exp});
    `CHK(last_err, 1'b0)
  endtask : host_fetch

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    chk(DEV, psp_pkg::ADDR_STATUS_DIR, 32'h07);
    chk(DEV, psp_pkg::ADDR_CTL_DATA, 32'h0);
    chk(DEV, psp_pkg::ADDR_PIN_CFG, 32'h0);
    chk(DEV, psp_pkg::ADDR_DATA_DIR, 32'hFF);
    chk(DEV, psp_pkg::ADDR_IRQ_FLAG, 32'h0);
    chk(DEV, 12'h100, 32'h0);
    `CHK(last_err, 1'b1)
    wr(DEV, psp_pkg::ADDR_STATUS_DIR, 32'hFF);
    chk(DEV, psp_pkg::ADDR_STATUS_DIR, 32'h37);
    wr(DEV, psp_pkg::ADDR_STATUS_DIR, 32'h07);
  endtask : test_reset

  task automatic test_pins();
    wr(DEV, psp_pkg::ADDR_PIN_CFG, 32'h37);
    chk(DEV, psp_pkg::ADDR_PIN_CFG, 32'h07);
    chk(DEV, psp_pkg::ADDR_CTL_DATA, 32'h07);
    wr(DEV, psp_pkg::ADDR_PIN_CFG, 32'h00);
    chk(DEV, psp_pkg::ADDR_CTL_DATA, 32'h00);
    wr(DEV, psp_pkg::ADDR_STATUS_DIR, 32'h06);
    `CHK(link.dev_ctl_oe, 3'b001)
    wr(DEV, psp_pkg::ADDR_STATUS_DIR, 32'h07);
    `CHK(link.dev_ctl_oe, 3'b000)
  endtask : test_pins

  task automatic test_mode_off();
    wr(DEV, psp_pkg::ADDR_DATA_LATCH, 32'h3C);
    chk(DEV, psp_pkg::ADDR_STATUS_DIR, 32'h07);
    host_send(8'h11);
    chk(DEV, psp_pkg::ADDR_STATUS_DIR, 32'h07);
    chk(DEV, psp_pkg::ADDR_IRQ_FLAG, 32'h0);
    host_fetch(8'hFF);
  endtask : test_mode_off

  task automatic test_host_write();
    wr(DEV, psp_pkg::ADDR_PIN_CFG, 32'h06);
    wr(DEV, psp_pkg::ADDR_STATUS_DIR, 32'h17);
    wr(HOST, psp_pkg::HADDR_TX, 32'hA5);
    wr(HOST, psp_pkg::HADDR_CMD, 32'h1);
    chk(DEV, psp_pkg::ADDR_STATUS_DIR, 32'h17);
    host_wait();
    chk(DEV, psp_pkg::ADDR_STATUS_DIR, 32'h97);
    chk(DEV, psp_pkg::ADDR_IRQ_FLAG, 32'h80);
    chk(DEV, psp_pkg::ADDR_DATA_LATCH, 32'hA5);
    chk(DEV, psp_pkg::ADDR_STATUS_DIR, 32'h17);
    wr(DEV, psp_pkg::ADDR_IRQ_FLAG, 32'h0);
  endtask : test_host_write

  task automatic test_overrun();
    host_send(8'h5A);
    host_send(8'hC3);
    chk(DEV, psp_pkg::ADDR_STATUS_DIR, 32'hB7);
    chk(DEV, psp_pkg::ADDR_DATA_LATCH, 32'hC3);
    chk(DEV, psp_pkg::ADDR_STATUS_DIR, 32'h37);
    wr(DEV, psp_pkg::ADDR_STATUS_DIR, 32'h17);
    chk(DEV, psp_pkg::ADDR_STATUS_DIR, 32'h17);
    wr(DEV, psp_pkg::ADDR_IRQ_FLAG, 32'h0);
  endtask : test_overrun

  task automatic test_host_read();
    wr(DEV, psp_pkg::ADDR_DATA_LATCH, 32'h3C);
    chk(DEV, psp_pkg::ADDR_STATUS_DIR, 32'h57);
    host_fetch(8'h3C);
    chk(DEV, psp_pkg::ADDR_STATUS_DIR, 32'h17);
    chk(DEV, psp_pkg::ADDR_IRQ_FLAG, 32'h80);
    wr(DEV, psp_pkg::ADDR_DATA_LATCH, 32'h66);
    wr(DEV, psp_pkg::ADDR_STATUS_DIR, 32'h07);
    chk(DEV, psp_pkg::ADDR_STATUS_DIR, 32'h07);
  endtask : test_host_read

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  // a hang counts as a mismatch and ends the run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end

  initial begin
    rst_n = 1'b0;
    paddr = 12'h000;
    psel_d = 1'b0;
    psel_h = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    test_reset();
    test_pins();
    test_mode_off();
    test_host_write();
    test_overrun();
    test_host_read();
    test_done();
  end
endmodule : parallel_slave_port_control_tb
`default_nettype wire
